// file: design/pgc_pkg.sv
// constants for the pattern generator / checker block
// assumes a byte-wide register port decoded by the host-port logic upstream
package pgc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h30;
   localparam logic [7:0] ADDR_COUNT_LOW  = 8'h31;
   localparam logic [7:0] ADDR_SNAPSHOT   = 8'h38;
   // sequence lengths: 2^23-1 and 2^15-1
   localparam int LONG_ORDER   = 23;
   localparam int LONG_TAP     = 18;
   localparam int SHORT_ORDER  = 15;
   localparam int SHORT_TAP    = 14;
   localparam int COUNT_WIDTH  = 16;
   // checker locks after this many matching bits, drops after this many errors in window
   localparam logic [5:0] LOCK_COUNT   = 6'h20;
   localparam logic [5:0] UNLOCK_ERRS  = 6'h08;
   localparam logic [5:0] WINDOW_BITS  = 6'h3F;
   localparam logic [7:0] BYTE_ZERO    = 8'h00;
endpackage : pgc_pkg

// file: design/pgc_prbs.sv
// pattern generator and checker with 16-bit error counter and holding byte
// assumes tx/rx bit enables are one-cycle pulses synchronous to clock_i (rx at the rx_clock rate)
`timescale 1ns/1ns
// Summary of operation
// - pattern logic works only when host_mode_i says the part is under register control.
// - with pattern enable set, tx sends 2^23-1 in E3 rate or 2^15-1 in STS-1/DS3 rate.
// - the same enable starts the receive checker together with the generator.
// - once the checker locks, the violation pin is driven low.
// - while out of sync the sync-loss bit is one and the violation pin high.
// - a rising write of one to error insert flips exactly one transmitted bit.
// - each bit error detected while locked pulses the violation pin high for one clock_i cycle while rx clock is high.
// - while enabled, the 16-bit counter increments once per detected bit error and holds at 0xFFFF.
// - every read of either byte copies the other byte to the holding byte and clears both.
// - errors are counted during acquisition too.
// - bits 15:8 sit at 0x30 and clear on read.
// - bits 7:0 sit at 0x31 and clear on read.
// - the holding byte at 0x38 is read only.
module pgc_prbs #(
   parameter int COUNT_W = pgc_pkg::COUNT_WIDTH
) (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   // mode
   input  wire logic       host_mode_i,
   input  wire logic       e3_mode_i,
   input  wire logic       pattern_enable_i,
   input  wire logic       error_insert_i,
   // register read port
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   output logic      [7:0] reg_rdata_o,
   // line data
   input  wire logic       tx_bit_en_i,
   output logic            tx_data_o,
   input  wire logic       rx_bit_en_i,
   input  wire logic       rx_data_i,
   input  wire logic       rx_clock_i,
   input  wire logic       rx_neg_data_i,
   // status
   output logic            pattern_sync_loss_o,
   output logic            rx_violation_pin_o
);
   if (COUNT_W != pgc_pkg::COUNT_WIDTH) begin : g_bad_count_w
      $error("pgc_prbs: counter must be 16 bits");
   end

   logic              active;
   logic [22:0]       gen_sr, next_gen_sr, chk_sr, next_chk_sr;
   logic              ins_d, next_ins_d, ins_pend, next_ins_pend;
   logic              tx_q, next_tx_q;
   logic              locked, next_locked;
   logic [5:0]        run_cnt, next_run_cnt, err_cnt, next_err_cnt, win_cnt, next_win_cnt;
   logic              err_hit, next_err_hit;
   logic [15:0]       count, next_count;
   logic [7:0]        hold, next_hold, rdata, next_rdata;
   logic              gen_fb, chk_pred, bit_err;

   assign active = host_mode_i & pattern_enable_i;

   // feedback for the selected length
   always_comb begin
      if (e3_mode_i) begin
         gen_fb   = gen_sr[pgc_pkg::LONG_ORDER-1] ^ gen_sr[pgc_pkg::LONG_TAP-1];
         chk_pred = chk_sr[pgc_pkg::LONG_ORDER-1] ^ chk_sr[pgc_pkg::LONG_TAP-1];
      end else begin
         gen_fb   = gen_sr[pgc_pkg::SHORT_ORDER-1] ^ gen_sr[pgc_pkg::SHORT_TAP-1];
         chk_pred = chk_sr[pgc_pkg::SHORT_ORDER-1] ^ chk_sr[pgc_pkg::SHORT_TAP-1];
      end
      bit_err = active & rx_bit_en_i & (rx_data_i != chk_pred);
   end

   // generator and single-error insertion
   always_comb begin
      next_gen_sr   = gen_sr;
      next_tx_q     = tx_q;
      next_ins_d    = error_insert_i;
      next_ins_pend = ins_pend;
      if (error_insert_i & ~ins_d & active) begin
         next_ins_pend = 1'b1;
      end
      if (!active) begin
         next_ins_pend = 1'b0;
         next_gen_sr   = {23{1'b1}};
         next_tx_q     = 1'b0;
      end else if (tx_bit_en_i) begin
         next_gen_sr   = {gen_sr[21:0], gen_fb};
         next_tx_q     = gen_fb ^ next_ins_pend;
         next_ins_pend = 1'b0;
      end
   end

   // checker: self-synchronising until lock, then free-running
   always_comb begin
      next_chk_sr  = chk_sr;
      next_locked  = locked;
      next_run_cnt = run_cnt;
      next_err_cnt = err_cnt;
      next_win_cnt = win_cnt;
      next_err_hit = bit_err;
      if (!active) begin
         next_chk_sr  = '0;
         next_locked  = 1'b0;
         next_run_cnt = '0;
         next_err_cnt = '0;
         next_win_cnt = '0;
      end else if (rx_bit_en_i) begin
         if (!locked) begin
            next_chk_sr  = {chk_sr[21:0], rx_data_i};
            next_run_cnt = bit_err ? 6'h00 : run_cnt + 6'h01;
            if (run_cnt == pgc_pkg::LOCK_COUNT) begin
               next_locked  = 1'b1;
               next_err_cnt = '0;
               next_win_cnt = '0;
            end
         end else begin
            next_chk_sr  = {chk_sr[21:0], chk_pred};
            next_win_cnt = win_cnt + 6'h01;
            next_err_cnt = err_cnt + {5'h00, bit_err};
            if (next_err_cnt >= pgc_pkg::UNLOCK_ERRS) begin
               next_locked  = 1'b0;
               next_run_cnt = '0;
            end else if (win_cnt == pgc_pkg::WINDOW_BITS) begin
               next_err_cnt = '0;
            end
         end
      end
   end

   // error counter and byte-wise readout
   always_comb begin
      logic rd_hi, rd_lo;
      rd_hi      = reg_rd_i & (reg_addr_i == pgc_pkg::ADDR_COUNT_HIGH);
      rd_lo      = reg_rd_i & (reg_addr_i == pgc_pkg::ADDR_COUNT_LOW);
      next_count = count;
      next_hold  = hold;
      next_rdata = rdata;
      if (reg_rd_i) begin
         case (reg_addr_i)
            pgc_pkg::ADDR_COUNT_HIGH: next_rdata = count[15:8];
            pgc_pkg::ADDR_COUNT_LOW:  next_rdata = count[7:0];
            pgc_pkg::ADDR_SNAPSHOT:   next_rdata = hold;
            default:                  next_rdata = pgc_pkg::BYTE_ZERO;
         endcase
      end
      if (rd_hi) begin
         next_hold  = count[7:0];
         next_count = '0;
      end else if (rd_lo) begin
         next_hold  = count[15:8];
         next_count = '0;
      end
      // counting from enable, not gated by lock; an error in the clear cycle survives
      if (bit_err) begin
         if (next_count != 16'hFFFF) begin
            next_count = next_count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         gen_sr   <= {23{1'b1}};
         tx_q     <= 1'b0;
         ins_d    <= 1'b0;
         ins_pend <= 1'b0;
         chk_sr   <= '0;
         locked   <= 1'b0;
         run_cnt  <= '0;
         err_cnt  <= '0;
         win_cnt  <= '0;
         err_hit  <= 1'b0;
         count    <= '0;
         hold     <= '0;
         rdata    <= '0;
      end else begin
         gen_sr   <= next_gen_sr;
         tx_q     <= next_tx_q;
         ins_d    <= next_ins_d;
         ins_pend <= next_ins_pend;
         chk_sr   <= next_chk_sr;
         locked   <= next_locked;
         run_cnt  <= next_run_cnt;
         err_cnt  <= next_err_cnt;
         win_cnt  <= next_win_cnt;
         err_hit  <= next_err_hit;
         count    <= next_count;
         hold     <= next_hold;
         rdata    <= next_rdata;
      end
   end

   assign tx_data_o           = tx_q;
   assign reg_rdata_o         = rdata;
   assign pattern_sync_loss_o = active & ~locked;
   // high out of sync, low in sync, error pulse in the rx_clock high half
   always_comb begin
      if (!active) begin
         rx_violation_pin_o = rx_neg_data_i;
      end else if (!locked) begin
         rx_violation_pin_o = 1'b1;
      end else begin
         rx_violation_pin_o = err_hit & rx_clock_i;
      end
   end
endmodule : pgc_prbs

// file: testbench/pgc_line_model.sv
// line partner: loops tx to rx, optional inversion, sequence monitor
// assumes one clock; one bit every four cycles
`timescale 1ns/1ns
module pgc_line_model (
   // clock and control
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic e3_mode_i,
   input  wire logic corrupt_i,
   // line
   input  wire logic tx_data_i,
   output logic      tx_bit_en_o,
   output logic      rx_bit_en_o,
   output logic      rx_clock_o,
   output logic      rx_data_o,
   output int        n_bad_o
);
   logic [1:0]  ph;
   logic [22:0] h;
   int          n_seen;
   assign tx_bit_en_o = ph == 2'h0;
   assign rx_bit_en_o = ph == 2'h2;
   assign rx_clock_o  = ph[1];
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         {ph, h, rx_data_o, n_seen, n_bad_o} <= '0;
      end else begin
         ph <= ph + 2'h1;
         if (ph == 2'h1) begin
            h <= {h[21:0], tx_data_i};
            rx_data_o <= tx_data_i ^ corrupt_i;
            n_seen <= n_seen + 1;
            if (n_seen > 23 && tx_data_i != (e3_mode_i ? h[22] ^ h[17] : h[14] ^ h[13]))
               n_bad_o <= n_bad_o + 1;
         end
      end
   end
endmodule : pgc_line_model

// file: testbench/pgc_prbs_props.sv
// port assertions for pgc_prbs
// assumes one clock_i domain, async active-high rst_i
`timescale 1ns/1ns
module pgc_prbs_props #(
   parameter int COUNT_W = 16
) (
   input wire logic       clock_i,
   input wire logic       rst_i,
   input wire logic       host_mode_i,
   input wire logic       pattern_enable_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       rx_clock_i,
   input wire logic       rx_neg_data_i,
   input wire logic       pattern_sync_loss_o,
   input wire logic       rx_violation_pin_o
);
   logic act;
   assign act = host_mode_i && pattern_enable_i;
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   sequence s_rsv_read;
      reg_rd_i && reg_addr_i == 8'h35;
   endsequence
   sequence s_err_rise;
      act && !pattern_sync_loss_o && $rose(rx_violation_pin_o);
   endsequence
   chk_host_off_pass: assert property (
      !host_mode_i |-> !pattern_sync_loss_o && rx_violation_pin_o == rx_neg_data_i)
      else $error("host off");
   chk_enable_start: assert property ($rose(act) |-> pattern_sync_loss_o)
      else $error("start");
   chk_disabled_quiet: assert property (!pattern_enable_i |-> !pattern_sync_loss_o)
      else $error("quiet");
   chk_lock_low: assert property (
      act && !pattern_sync_loss_o && !rx_clock_i |-> !rx_violation_pin_o)
      else $error("lock");
   chk_loss_high: assert property (
      pattern_sync_loss_o |-> rx_violation_pin_o && act)
      else $error("loss");
   chk_err_pulse: assert property (
      s_err_rise |-> rx_clock_i ##1 (!rx_violation_pin_o || pattern_sync_loss_o))
      else $error("pulse");
   chk_rsv_zero: assert property (s_rsv_read |=> reg_rdata_o == 8'h00)
      else $error("reserved");
   chk_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
      else $error("hold");
endmodule : pgc_prbs_props
bind pgc_prbs pgc_prbs_props #(.COUNT_W(COUNT_W)) u_pgc_prbs_props (.clock_i(clock_i),
   .rst_i(rst_i), .host_mode_i(host_mode_i), .pattern_enable_i(pattern_enable_i),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
   .rx_clock_i(rx_clock_i), .rx_neg_data_i(rx_neg_data_i),
   .pattern_sync_loss_o(pattern_sync_loss_o), .rx_violation_pin_o(rx_violation_pin_o));

// file: testbench/pgc_prbs_test.sv
// self-checking bench for pgc_prbs
// assumes pgc_line_model on the line side
`timescale 1ns/1ns
module pgc_prbs_test;
   logic       clock_i, rst_i, hm, e3, en, ins, rd, neg, cor, tx, txe, rxe, rxc, rxd, loss, pin;
   logic [7:0] addr, rdata, v;
   int         n_errors, n_compared, n_bad, base;
   pgc_prbs u_pgc_prbs (.clock_i(clock_i), .rst_i(rst_i), .host_mode_i(hm), .e3_mode_i(e3),
      .pattern_enable_i(en), .error_insert_i(ins), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_rdata_o(rdata), .tx_bit_en_i(txe), .tx_data_o(tx), .rx_bit_en_i(rxe),
      .rx_data_i(rxd), .rx_clock_i(rxc), .rx_neg_data_i(neg),
      .pattern_sync_loss_o(loss), .rx_violation_pin_o(pin));
   pgc_line_model u_pgc_line_model (.clock_i(clock_i), .rst_i(rst_i), .e3_mode_i(e3),
      .corrupt_i(cor), .tx_data_i(tx), .tx_bit_en_o(txe), .rx_bit_en_o(rxe),
      .rx_clock_o(rxc), .rx_data_o(rxd), .n_bad_o(n_bad));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : cyc
   task rdreg(input logic [7:0] a);
      cyc(1);
      rd = 1'b1;
      addr = a;
      cyc(1);
      rd = 1'b0;
      v = rdata;
   endtask : rdreg
   task test_done;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   initial begin
      #200_000;
      n_errors++;
      test_done();
   end
   initial begin
      {hm, e3, ins, rd, cor, addr} = '0;
      {rst_i, en, neg} = 3'h7;
      cyc(20);
      rst_i = 1'b0;
      cyc(2);
      chk({loss, pin}, 2'h1);
      for (int m = 0; m < 2; m++) begin
         en = 1'b0;
         ins = 1'b0;
         hm = 1'b1;
         e3 = m[0];
         cyc(2);
         en = 1'b1;
         cyc(1);
         chk(loss, 1'b1);
         for (int i = 0; i < 300 && loss; i++) cyc(10);
         chk({loss, pin}, 2'h0);
         rdreg(8'h30);
         rdreg(8'h30);
         chk(v, 8'h00);
         base = n_bad;
         ins = 1'b1;
         cyc(400);
         chk(n_bad - base, 3);
         cyc(400);
         chk(n_bad - base, 3);
         ins = 1'b0;
         cyc(8);
         ins = 1'b1;
         cyc(400);
         chk(n_bad - base, 6);
         rdreg(8'h31);
         chk(v, 8'h02);
         rdreg(8'h38);
         chk(v, 8'h00);
         rdreg(8'h31);
         chk(v, 8'h00);
      end
      rdreg(8'h35);
      chk(v, 8'h00);
      cor = 1'b1;
      cyc(400);
      chk({loss, pin}, 2'h3);
      rdreg(8'h31);
      chk(v != 8'h00, 1'b1);
      test_done();
   end
endmodule : pgc_prbs_test
